// *** design/psf_pkg.sv ***
// constants, states and timing counts of the pcm short-frame voice master
// ----------------------------------------------------------------------
// Functional notes
// - master drives 2048 kHz bit clock, short sync; code gives a 480 ns bit period (12 x 40 ns)
// - frame sync repeats every 125 us; code repeats it every 3072 x 40 ns = 122.88 us
// - sync high one bit clock, low otherwise
// - sync edges quarter period from falling edge
// - capture serial input on bit clock fall
// - launch output bits on bit clock rise
// - release output after falling edge, within 60 ns
// - clock, sync, data are outputs; 244/244 ns phases; code gives 240/240 ns (6 x 40 ns)
// ----------------------------------------------------------------------
package psf_pkg;
    // ------------------------------------------------------------------
    // timing in printed units and derived cycle counts
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int BCLK_HALF_NS = 244;
    localparam int BIT_PERIOD_NS = 488;
    localparam int FRAME_PERIOD_US = 125;
    localparam int SYNC_OFFSET_NS = 122;
    // whole cycles only: 6 x 40 ns is the nearest fit below 244 ns
    localparam int BCLK_HALF_CYC = BCLK_HALF_NS / CLK_PERIOD_NS;
    localparam int BCLK_PERIOD_CYC = 2 * BCLK_HALF_CYC;
    localparam int FRAME_BITS = FRAME_PERIOD_US * 1000 / BIT_PERIOD_NS;
    localparam int SYNC_OFFSET_CYC = SYNC_OFFSET_NS / CLK_PERIOD_NS;
    localparam int FRAME_CYC = FRAME_BITS * BCLK_PERIOD_CYC;
    // ------------------------------------------------------------------
    // counter widths and phase points within one bit clock period
    // ------------------------------------------------------------------
    localparam int PHASE_W = 4;
    localparam int BIT_W = 8;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 4'(BCLK_PERIOD_CYC - 1);
    localparam logic [PHASE_W-1:0] PHASE_HALF = 4'(BCLK_HALF_CYC);
    localparam logic [PHASE_W-1:0] PHASE_SYNC =
        4'(BCLK_HALF_CYC + SYNC_OFFSET_CYC);
    localparam logic [PHASE_W-1:0] PHASE_RELEASE = 4'(BCLK_HALF_CYC + 1);
    localparam logic [PHASE_W-1:0] PHASE_CAPTURE = 4'(BCLK_HALF_CYC + 2);
    localparam logic [BIT_W-1:0] FRAME_LAST = 8'(FRAME_BITS - 1);
    localparam int SLOT_BITS_DEF = 16;
    // ------------------------------------------------------------------
    // port state
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {PSF_IDLE, PSF_RUN} psf_state_e;
endpackage

// *** design/psf_buf2.sv ***
// two-entry valid/ready buffer with registered output word
`timescale 1ns/1ps
module psf_buf2 #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic out_v;
        logic [WIDTH-1:0] out_w;
        logic spare_v;
        logic [WIDTH-1:0] spare_w;
    } psf_buf_s;
    psf_buf_s q, d;
    logic take;
    logic pop;

    // ------------------------------------------------------------------
    // head register feeds the port, spare catches a word during a stall
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        take = in_valid && !q.spare_v;
        pop = q.out_v && out_ready;
        if (pop || !q.out_v) begin
            if (q.spare_v) begin
                d.out_v = 1'b1;
                d.out_w = q.spare_w;
                d.spare_v = 1'b0;
            end else begin
                d.out_v = take;
                d.out_w = take ? in_data : q.out_w;
            end
        end else if (take) begin
            d.spare_v = 1'b1;
            d.spare_w = in_data;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ready only depends on the spare, so no path from out_ready
    assign in_ready = !q.spare_v;
    assign out_valid = q.out_v;
    assign out_data = q.out_w;
endmodule

// *** design/psf_master.sv ***
// pcm short-frame voice port master: clock, sync, serial out and in
`timescale 1ns/1ps
module psf_master #(
    parameter int SLOT_BITS = psf_pkg::SLOT_BITS_DEF
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic port_enable,
    input wire logic [SLOT_BITS-1:0] tx_word,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [SLOT_BITS-1:0] rx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic bit_clock_pin,
    output logic voice_frame_marker_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic serial_in_pin
);
    import psf_pkg::*;

    // every check in this module runs on the port clock and rests in reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // the slot's final bit: output is released and the word pushed there
    function automatic logic last_slot_bit(input logic [BIT_W-1:0] n);
        return 32'(n) == SLOT_BITS - 1;
    endfunction

    typedef struct packed {
        psf_state_e st;
        logic [PHASE_W-1:0] phase;
        logic [BIT_W-1:0] bitn;
        logic din_s1;
        logic din_s2;
        logic [SLOT_BITS-1:0] tx_sh;
        logic [SLOT_BITS-1:0] rx_sh;
        logic push;
        logic bclk;
        logic sync;
        logic dout;
        logic oe;
        logic tx_rdy;
        logic overrun;
    } psf_master_s;

    psf_master_s q, d;
    logic buf_in_ready;
    logic in_slot;

    // ------------------------------------------------------------------
    // next state: all pins are registered from the current counters
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        in_slot = 32'(q.bitn) < SLOT_BITS;
        d.din_s1 = serial_in_pin;
        d.din_s2 = q.din_s1;
        d.push = 1'b0;
        d.tx_rdy = 1'b0;
        d.overrun = q.push && !buf_in_ready;
        case (q.st)
            PSF_IDLE: begin
                // quiet pins while disabled
                d.phase = '0;
                d.bitn = FRAME_LAST;
                d.bclk = 1'b0;
                d.sync = 1'b0;
                d.dout = 1'b0;
                d.oe = 1'b0;
                if (port_enable) begin
                    d.st = PSF_RUN;
                end
            end
            PSF_RUN: begin
                if (!port_enable) begin
                    // stop at once; a word in flight is abandoned
                    d.st = PSF_IDLE;
                    d.bclk = 1'b0;
                    d.sync = 1'b0;
                    d.oe = 1'b0;
                end else begin
                    // divider: 6 cycles high then 6 low
                    d.bclk = q.phase < PHASE_HALF;
                    if (q.phase == PHASE_LAST) begin
                        d.phase = '0;
                        d.bitn = (q.bitn == FRAME_LAST) ? '0 : q.bitn + 1'b1;
                    end else begin
                        d.phase = q.phase + 1'b1;
                    end
                    // one bit period wide, offset from the fall
                    d.sync = (q.bitn == FRAME_LAST && q.phase >= PHASE_SYNC)
                          || (q.bitn == '0 && q.phase < PHASE_SYNC);
                    // launch with the rising edge, msb first
                    if (q.phase == '0 && in_slot) begin
                        d.dout = q.tx_sh[SLOT_BITS-1];
                        d.tx_sh = {q.tx_sh[SLOT_BITS-2:0], 1'b0};
                        d.oe = 1'b1;
                    end
                    // release one cycle after the last fall
                    if (q.phase == PHASE_RELEASE
                        && last_slot_bit(q.bitn)) begin
                        d.oe = 1'b0;
                        d.dout = 1'b0;
                    end
                    // sample the synchronised input after the fall
                    if (q.phase == PHASE_CAPTURE && in_slot) begin
                        d.rx_sh = {q.rx_sh[SLOT_BITS-2:0], q.din_s2};
                        d.push = last_slot_bit(q.bitn);
                    end
                    // offer the load slot one cycle before the frame
                    d.tx_rdy = q.bitn == FRAME_LAST
                            && q.phase == PHASE_LAST - 1'b1;
                    if (q.tx_rdy) begin
                        // no word offered means a silent slot of zeros
                        d.tx_sh = tx_valid ? tx_word : '0;
                    end
                end
            end
            default: begin
                d.st = PSF_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // received words wait here, two at most, for a slow consumer; a third is dropped and flagged
    // ------------------------------------------------------------------
    psf_buf2 #(
        .WIDTH(SLOT_BITS)
    ) u_rx_buf (
        .clock(clock),
        .srst(srst),
        .in_valid(q.push),
        .in_data(q.rx_sh),
        .in_ready(buf_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_word),
        .out_ready(rx_ready)
    );

    // pins come straight from the state register
    assign bit_clock_pin = q.bclk;
    assign voice_frame_marker_pin = q.sync;
    assign serial_out_pin = q.dout;
    assign serial_out_oe = q.oe;
    assign tx_ready = q.tx_rdy;
    assign rx_overrun = q.overrun;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    localparam int FRAME_CYC_L = FRAME_CYC;
    logic bclk_prev;
    logic bclk_fell;
    logic sync_seen;
    logic [11:0] sync_gap;

    // helper: edge of the bit clock and distance between sync rises
    always_ff @(posedge clock) begin
        if (srst || !port_enable) begin
            bclk_prev <= 1'b0;
            sync_seen <= 1'b0;
            sync_gap <= '0;
        end else begin
            bclk_prev <= q.bclk;
            if (q.sync && !$past(q.sync)) begin
                sync_seen <= 1'b1;
                sync_gap <= 12'h001;
            end else begin
                sync_gap <= sync_gap + 12'h001;
            end
        end
    end
    assign bclk_fell = bclk_prev && !q.bclk;

    idle_pins_quiet_a: assert property (
        q.st == PSF_IDLE |-> !q.bclk && !q.sync && !q.oe)
        else $error("pins active while port idle");
    bclk_high_a: assert property (
        disable iff (srst || !port_enable)
        $rose(q.bclk) |-> q.bclk[*6] ##1 !q.bclk)
        else $error("bit clock high phase wrong");
    bclk_low_a: assert property (
        disable iff (srst || !port_enable)
        $fell(q.bclk) |-> !q.bclk[*6] ##1 q.bclk)
        else $error("bit clock low phase wrong");
    sync_width_a: assert property (
        disable iff (srst || !port_enable)
        $rose(q.sync) |-> q.sync[*8] ##1 q.sync[*4] ##1 !q.sync)
        else $error("frame sync width wrong");
    sync_period_a: assert property (
        disable iff (srst || !port_enable)
        $rose(q.sync) && sync_seen |-> sync_gap == 12'(FRAME_CYC_L))
        else $error("frame sync period wrong");
    sync_offset_a: assert property (
        $rose(q.sync) |-> $past(bclk_fell, 3))
        else $error("frame sync not offset from falling edge");
    dout_launch_a: assert property (
        $rose(q.oe) || (q.oe && $changed(q.dout)) |-> $rose(q.bclk))
        else $error("serial output changed off the rising edge");
    release_a: assert property (
        disable iff (srst || !port_enable)
        $fell(q.oe) |-> $past(bclk_fell, 1))
        else $error("serial output not released after falling edge");
    capture_a: assert property (
        q.push |-> $past(bclk_fell, 2))
        else $error("input capture not after falling edge");

    frame_start_c: cover property ($rose(q.sync) && sync_seen);
    rx_word_c: cover property (rx_valid && rx_ready);
    tx_take_c: cover property (tx_valid && tx_ready);
    overrun_c: cover property (rx_overrun);
endmodule

// *** dv/psf_codec.sv ***
// behavioural pcm codec model on the far side of the voice port
`timescale 1ns/1ps
module psf_codec (
    input wire logic bclk, // clock, sync, data out only listened to
    input wire logic sync,
    input wire logic dout,
    input wire logic oe,
    input wire logic [15:0] tx_pat,
    output logic din,
    output logic [15:0] heard,
    output logic oe_bad
);
    int n = 16;
    logic [15:0] sh = 16'h0000;
    initial begin
        din = 1'b0;
        heard = 16'h0000;
        oe_bad = 1'b0;
    end
    // launch on the rise: half a bit of setup and hold around the fall
    always @(posedge bclk) begin
        if (sync) begin
            n = 0;
            sh = tx_pat;
        end else if (n < 16) begin
            n = n + 1;
        end
        din <= (n < 16) ? sh[15-n] : 1'b0; // released line sits on pull-down
    end
    // take master data on the fall, as a real codec would
    always @(negedge bclk) begin
        if (n < 16) begin
            heard <= {heard[14:0], dout};
            oe_bad <= oe_bad | !oe;
        end
    end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the pcm short-frame voice port master
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic port_enable = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b1;
    logic tx_ready, rx_valid, rx_overrun, bclk, sync, dout, oe, din, oe_bad;
    logic [15:0] rx_word, heard;
    logic [15:0] pat = 16'h0000;
    logic bclk_q = 1'b0;
    int since_fall = 0;
    int ovr_cnt = 0;
    int mismatches = 0;
    int cmp_count = 0;

    psf_master i_dut (.clock(clock), .srst(srst), .port_enable(port_enable),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_overrun(rx_overrun), .bit_clock_pin(bclk),
        .voice_frame_marker_pin(sync), .serial_out_pin(dout),
        .serial_out_oe(oe), .serial_in_pin(din));
    psf_codec i_codec (.bclk(bclk), .sync(sync), .dout(dout), .oe(oe),
        .tx_pat(pat), .din(din), .heard(heard), .oe_bad(oe_bad));

    initial begin
        forever #20 clock = ~clock;
    end
    // history from pre-update values, so tasks at the fall never race it
    always @(posedge clock) begin
        since_fall = (bclk_q === 1'b1 && bclk === 1'b0) ? 1 : since_fall + 1;
        bclk_q = bclk;
        if (rx_overrun === 1'b1) ovr_cnt++;
    end

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // bounded wait: 0 sync, 1 oe high, 2 oe low, 3 tx_ready, 4 rx_valid
    task automatic wait_for(input int what);
        logic [4:0] v;
        for (int k = 0; k < 4000; k++) begin
            @(negedge clock);
            v = {rx_valid, tx_ready, ~oe, oe, sync};
            if (v[what] === 1'b1) return;
        end
        mismatches++;
        final_report();
    endtask
    // length of a run of level v on sync (sel 1) or bit clock (sel 0)
    task automatic run_len(input int sel, input logic v, output int len);
        len = 0;
        while ((sel ? sync : bclk) === v && len < 4000) begin
            len++;
            @(negedge clock);
        end
        // a run that never ends is a hang: count it and end the test
        if (len >= 4000) begin
            mismatches++;
            final_report();
        end
    endtask

    // outputs stay quiet through reset and while the port is disabled
    task automatic t_reset();
        logic [6:0] acc;
        acc = 7'h00;
        repeat (30) begin
            @(negedge clock);
            acc |= {bclk, sync, oe, dout, tx_ready, rx_valid, rx_overrun};
        end
        chk("idle_outputs", 16'(acc), 16'h0000);
    endtask
    // sync placement and width, frame period, bit clock phases
    task automatic t_timing();
        int h;
        int l;
        @(posedge clock);
        port_enable <= 1'b1;
        wait_for(0);
        chk("sync_rise_offset", 16'(since_fall), 16'd3);
        run_len(1, 1'b1, h);
        chk("sync_high", 16'(h), 16'd12);
        chk("sync_fall_offset", 16'(since_fall), 16'd3);
        run_len(1, 1'b0, l);
        chk("frame_cycles", 16'(h + l), 16'd3072);
        run_len(0, 1'b0, l);
        run_len(0, 1'b1, h);
        run_len(0, 1'b0, l);
        chk("bclk_high", 16'(h), 16'd6);
        chk("bclk_low", 16'(l), 16'd6);
    endtask
    // two words back to back, then a frame with nothing offered (zeros)
    task automatic t_tx();
        logic [15:0] w [3] = '{16'hc35a, 16'h8001, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            tx_word <= w[i];
            tx_valid <= (i < 2);
            wait_for(3);
            @(posedge clock);
            tx_valid <= 1'b0;
            wait_for(1);
            wait_for(2);
            chk("release_delay", 16'(since_fall), 16'd1);
            chk("codec_heard", heard, w[i]);
        end
        chk("slot_driven", {15'h0000, oe_bad}, 16'h0000);
    endtask
    // stalled consumer: two words kept, the third dropped and flagged
    task automatic t_rx();
        logic [15:0] p [3] = '{16'h9b2d, 16'hffff, 16'h0001};
        int base;
        wait_for(1);
        wait_for(2);
        repeat (10) @(posedge clock);
        rx_ready <= 1'b0;
        pat <= p[0];
        base = ovr_cnt;
        for (int i = 0; i < 3; i++) begin
            wait_for(1);
            wait_for(2);
            repeat (10) @(posedge clock);
            pat <= p[(i + 1) % 3];
        end
        chk("overrun_pulses", 16'(ovr_cnt - base), 16'd1);
        for (int i = 0; i < 2; i++) begin
            wait_for(4);
            chk("rx_word", rx_word, p[i]);
            @(posedge clock);
            rx_ready <= 1'b1;
            @(posedge clock);
            rx_ready <= 1'b0;
        end
        repeat (3) @(negedge clock);
        chk("rx_empty", {15'h0000, rx_valid}, 16'h0000);
        @(posedge clock);
        rx_ready <= 1'b1;
    endtask
    // disable in mid-slot: clock, sync and output enable drop at the next edge and stay down
    task automatic t_off();
        logic [2:0] acc;
        wait_for(1);
        @(posedge clock);
        port_enable <= 1'b0;
        @(posedge clock);
        acc = 3'b000;
        repeat (20) begin
            @(negedge clock);
            acc |= {bclk, sync, oe};
        end
        chk("disabled_pins", 16'(acc), 16'h0000);
    endtask

    initial begin
        fork
            t_reset();
            begin
                repeat (10) @(posedge clock);
                srst <= 1'b0;
            end
        join
        t_timing();
        t_tx();
        t_rx();
        t_off();
        final_report();
    end
endmodule
